/* adc_pls_pkg.sv */
// Constants shared by the point-list sequencer block
`default_nettype none
package adc_pls_pkg;
    // Register offsets on the card's I/O window
    localparam logic [2:0] OFS_CONV_RESULT_LO = 3'h0;
    localparam logic [2:0] OFS_RESULT_HI_TAG  = 3'h1;
    localparam logic [2:0] OFS_POINT_LIST_LO  = 3'h2;
    localparam logic [2:0] OFS_POINT_LIST_HI  = 3'h3;
    localparam logic [2:0] OFS_OPTION_STATUS  = 3'h4;
    // Option control bit positions
    localparam int OPT_EXT_TRIG_EN   = 7;
    localparam int OPT_POINT_CLR     = 6;
    localparam int OPT_RESULT_CLR    = 3;
    localparam int OPT_HALF_IRQ_EN   = 2;
    localparam int OPT_ERR_IRQ_EN    = 1;
    localparam int OPT_TIMER_TRIG_EN = 0;
    localparam logic [7:0] OPT_RESET = 8'h00;
    // Point-list entry fields
    localparam int PL_RANGE_LSB = 0;
    localparam int PL_PAIR_BIT  = 3;
    localparam int PL_CHAN_LSB  = 4;
    localparam int PL_GAIN_LSB  = 8;
    localparam int PL_TAG_LSB   = 12;
    // Result word fields
    localparam int RES_DATA_W  = 12;
    localparam int RES_TAG_LSB = 12;
    // Conversion engine states
    typedef enum logic [0:0] {CONV_IDLE, CONV_BUSY} conv_state_e;
endpackage : adc_pls_pkg
`default_nettype wire

/* adc_pointlist_sequencer.sv */
// Point-list sequencer, result queue and option/status registers of the A/D card
// Functional notes
// - A write to offset 0 while idle starts one conversion on current point-list entry.
// - Writes to offset 1 change nothing.
// - Reads of offsets 0 and 1 return results oldest first.
// - Result word: 12-bit two's complement in bits 11-0, tag in top four.
// - Tag equals selector bits of the entry that started the conversion.
// - Each word write to offset 2 pushes an entry; up to 2048 entries.
// - Reading offset 2 returns the point-list control word readback.
// - Entry bits 7-4 channel, bit 3 input mode, bits 2-0 range code.
// - Mode 0 single-ended sixteen channels; mode 1 differential, eight channels.
// - Range code selects one of eight converter ranges.
// - Bits 15-12 selector and 10-8 gain drive sub-mux outputs; bit 11 unused.
// - With option bit 7 set, a high external pin starts conversions.
// - Option bit 6 empties the point list; bit 3 empties the result queue.
// - Option bit 2 enables interrupt when result queue reaches half full.
// - Option bit 1 enables interrupt on empty read or result lost when full.
// - Option bit 0 starts a conversion on each timer channel 2 zero count while idle.
// - Reading offset 4 returns status and clears the pending interrupt.
// - Status bit 7 reads 0 while converting, 1 when idle.
// - Status bits 6-1 are active-low full, half, empty of both queues.
`default_nettype none
module adc_pointlist_sequencer #(
    parameter int PL_DEPTH  = 2048,
    parameter int RES_DEPTH = 1024
) (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_SYS_RST,
    // Host I/O access
    input  wire logic [2:0]  I_ADDR,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    input  wire logic        I_WORD,
    input  wire logic [15:0] I_WDATA,
    output logic      [15:0] O_RDATA,
    output logic             O_RVALID,
    output logic             O_IRQ,
    // Trigger sources
    input  wire logic        I_EXT_PIN_LEVEL,
    input  wire logic        I_TIMER2_ZERO,
    // Converter and sub-mux side
    output logic             O_CONV_START,
    output logic      [3:0]  O_CHANNEL_NUMBER,
    output logic             O_PAIR_INPUT_MODE,
    output logic      [2:0]  O_RANGE_CODE,
    output logic      [3:0]  O_TAG_SELECT_BITS,
    output logic      [2:0]  O_GAIN_BITS,
    input  wire logic        I_CONV_DONE,
    input  wire logic [11:0] I_CONV_DATA
);
    localparam int PLW = $clog2(PL_DEPTH);
    localparam int RSW = $clog2(RES_DEPTH);

    // Result pointers wrap naturally, so the result depth must be a power of two
    if (PL_DEPTH < 2 || RES_DEPTH < 2 || (RES_DEPTH & (RES_DEPTH - 1)) != 0) begin : g_chk
        $error("adc_pointlist_sequencer: unsupported queue depth");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access decode
    logic wr_start, wr_point, wr_opt, rd_pop, rd_lo, rd_point, rd_stat;
    assign wr_start = I_WR && I_ADDR == adc_pls_pkg::OFS_CONV_RESULT_LO;
    assign wr_point = I_WR && I_WORD && I_ADDR == adc_pls_pkg::OFS_POINT_LIST_LO;
    assign wr_opt   = I_WR && I_ADDR == adc_pls_pkg::OFS_OPTION_STATUS;
    // Word read at 0 or byte read of the high half pops, keeping halves paired
    assign rd_lo    = I_RD && I_ADDR == adc_pls_pkg::OFS_CONV_RESULT_LO;
    assign rd_pop   = (rd_lo && I_WORD) ||
                      (I_RD && I_ADDR == adc_pls_pkg::OFS_RESULT_HI_TAG);
    assign rd_point = I_RD && I_ADDR == adc_pls_pkg::OFS_POINT_LIST_LO && I_WORD;
    assign rd_stat  = I_RD && I_ADDR == adc_pls_pkg::OFS_OPTION_STATUS;

    ////////////////////////////////////////////////////////////////////////////
    // Option register; clear bits act as pulses and are not stored
    logic [7:0] opt_q, opt_d;
    logic       pl_clr, rs_clr;
    assign pl_clr = wr_opt && I_WDATA[adc_pls_pkg::OPT_POINT_CLR];
    assign rs_clr = wr_opt && I_WDATA[adc_pls_pkg::OPT_RESULT_CLR];

    always_comb begin
        opt_d = opt_q;
        if (wr_opt) begin
            opt_d = I_WDATA[7:0] & 8'h87;
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            opt_q <= adc_pls_pkg::OPT_RESET;
        end else begin
            opt_q <= opt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Point-list storage; entries are appended, conversions walk them in order
    logic [15:0]  pl_mem [PL_DEPTH];
    logic [PLW:0] pl_cnt_q, pl_cnt_d;
    logic [PLW:0] seq_q, seq_d;
    logic [15:0]  pl_head;
    logic         pl_full, pl_half, pl_empty;
    assign pl_full  = pl_cnt_q == (PLW + 1)'(PL_DEPTH);
    assign pl_half  = pl_cnt_q >= (PLW + 1)'(PL_DEPTH / 2);
    assign pl_empty = pl_cnt_q == '0;
    assign pl_head  = pl_empty ? 16'h0000 : pl_mem[seq_q[PLW-1:0]];

    always_ff @(posedge I_CLK) begin
        if (wr_point && !pl_full && !pl_clr) begin
            pl_mem[pl_cnt_q[PLW-1:0]] <= I_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result queue of tagged words
    logic [15:0]  rs_mem [RES_DEPTH];
    logic [RSW-1:0] rs_wp_q, rs_wp_d, rs_rp_q, rs_rp_d;
    logic [RSW:0] rs_cnt_q, rs_cnt_d;
    logic         rs_full, rs_half, rs_empty, rs_push, rs_pop, rs_lost, rs_under;
    logic [15:0]  rs_word, cur_q, cur_d; // Current entry declared here, the tag needs it
    assign rs_full  = rs_cnt_q == (RSW + 1)'(RES_DEPTH);
    assign rs_half  = rs_cnt_q >= (RSW + 1)'(RES_DEPTH / 2);
    assign rs_empty = rs_cnt_q == '0;
    assign rs_word  = {cur_q[adc_pls_pkg::PL_TAG_LSB +: 4], I_CONV_DATA};

    ////////////////////////////////////////////////////////////////////////////
    // Conversion engine
    adc_pls_pkg::conv_state_e st_q, st_d;
    logic        start_req, start, done;
    // Level trigger keeps converting while the pin stays high
    assign start_req = wr_start ||
                       (opt_q[adc_pls_pkg::OPT_EXT_TRIG_EN] && I_EXT_PIN_LEVEL) ||
                       (opt_q[adc_pls_pkg::OPT_TIMER_TRIG_EN] && I_TIMER2_ZERO);
    // Triggers arriving mid-conversion are dropped, not queued
    assign start = st_q == adc_pls_pkg::CONV_IDLE && start_req;
    assign done  = st_q == adc_pls_pkg::CONV_BUSY && I_CONV_DONE;

    always_comb begin
        st_d = st_q;
        cur_d = cur_q;
        seq_d = seq_q;
        pl_cnt_d = pl_cnt_q;
        unique case (st_q)
            adc_pls_pkg::CONV_IDLE: begin
                if (start) begin
                    st_d = adc_pls_pkg::CONV_BUSY;
                    cur_d = pl_head;
                end
            end
            adc_pls_pkg::CONV_BUSY: begin
                if (done) begin
                    st_d = adc_pls_pkg::CONV_IDLE;
                    seq_d = (seq_q + 1'b1 >= pl_cnt_q) ? '0 : seq_q + 1'b1;
                end
            end
        endcase
        if (wr_point && !pl_full) begin
            pl_cnt_d = pl_cnt_q + 1'b1;
        end
        if (rd_point) begin
            seq_d = '0;
        end
        if (pl_clr) begin
            pl_cnt_d = '0;
            seq_d = '0;
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            st_q <= adc_pls_pkg::CONV_IDLE;
            cur_q <= 16'h0000;
            seq_q <= '0;
            pl_cnt_q <= '0;
        end else begin
            st_q <= st_d;
            cur_q <= cur_d;
            seq_q <= seq_d;
            pl_cnt_q <= pl_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result queue pointers and flags
    assign rs_push  = done && !rs_full && !rs_clr;
    assign rs_lost  = done && rs_full && !rs_clr;
    assign rs_pop   = rd_pop && !rs_empty && !rs_clr;
    assign rs_under = rd_pop && rs_empty;

    always_comb begin
        rs_wp_d = rs_wp_q;
        rs_rp_d = rs_rp_q;
        rs_cnt_d = rs_cnt_q;
        if (rs_push) begin
            rs_wp_d = rs_wp_q + 1'b1;
        end
        if (rs_pop) begin
            rs_rp_d = rs_rp_q + 1'b1;
        end
        rs_cnt_d = rs_cnt_q + (RSW + 1)'(rs_push) - (RSW + 1)'(rs_pop);
        if (rs_clr) begin
            rs_wp_d = '0;
            rs_rp_d = '0;
            rs_cnt_d = '0;
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            rs_wp_q <= '0;
            rs_rp_q <= '0;
            rs_cnt_q <= '0;
        end else begin
            rs_wp_q <= rs_wp_d;
            rs_rp_q <= rs_rp_d;
            rs_cnt_q <= rs_cnt_d;
        end
    end

    // Result storage is data only, no reset needed
    always_ff @(posedge I_CLK) begin
        if (rs_push) begin
            rs_mem[rs_wp_q] <= rs_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt: half-full crossing or queue error, cleared by status read
    logic irq_q, irq_d, rs_half_q, irq_set;
    assign irq_set = (opt_q[adc_pls_pkg::OPT_HALF_IRQ_EN] && rs_half && !rs_half_q) ||
                     (opt_q[adc_pls_pkg::OPT_ERR_IRQ_EN] && (rs_lost || rs_under));

    always_comb begin
        irq_d = irq_q;
        if (rd_stat) begin
            irq_d = 1'b0;
        end
        if (irq_set) begin
            irq_d = 1'b1;                                                          // set wins
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            irq_q <= 1'b0;
            rs_half_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
            rs_half_q <= rs_half;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data path, one cycle after the strobe
    logic [15:0] rdata_q, rdata_d, rd_word, status;
    logic        rvalid_q;
    assign rd_word = rs_empty ? 16'h0000 : rs_mem[rs_rp_q];
    assign status = {8'h00, st_q == adc_pls_pkg::CONV_IDLE,
                     !pl_full, !pl_half, !pl_empty, !rs_full, !rs_half, !rs_empty,
                     I_EXT_PIN_LEVEL};

    always_comb begin
        rdata_d = 16'h0000;
        unique case (I_ADDR)
            adc_pls_pkg::OFS_CONV_RESULT_LO: rdata_d = I_WORD ? rd_word : {8'h00, rd_word[7:0]};
            adc_pls_pkg::OFS_RESULT_HI_TAG:  rdata_d = {8'h00, rd_word[15:8]};
            adc_pls_pkg::OFS_POINT_LIST_LO:  rdata_d = I_WORD ? pl_head : {8'h00, pl_head[7:0]};
            adc_pls_pkg::OFS_POINT_LIST_HI:  rdata_d = {8'h00, pl_head[15:8]};
            adc_pls_pkg::OFS_OPTION_STATUS:  rdata_d = status;
            default:                         rdata_d = 16'h0000;
        endcase
        if (!I_RD) begin
            rdata_d = rdata_q;
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= I_RD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs; sub-mux and converter fields come from the latched entry
    assign O_RDATA           = rdata_q;
    assign O_RVALID          = rvalid_q;
    assign O_IRQ             = irq_q;
    assign O_CONV_START      = start;
    assign O_CHANNEL_NUMBER  = cur_q[adc_pls_pkg::PL_CHAN_LSB +: 4];
    assign O_PAIR_INPUT_MODE = cur_q[adc_pls_pkg::PL_PAIR_BIT];
    assign O_RANGE_CODE      = cur_q[adc_pls_pkg::PL_RANGE_LSB +: 3];
    assign O_TAG_SELECT_BITS = cur_q[adc_pls_pkg::PL_TAG_LSB +: 4];
    assign O_GAIN_BITS       = cur_q[adc_pls_pkg::PL_GAIN_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_sw_start_idle: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        wr_start && st_q == adc_pls_pkg::CONV_IDLE |-> O_CONV_START ##1 st_q == adc_pls_pkg::CONV_BUSY)
        else $error("software start did not begin a conversion");
    a_wr1_no_effect: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        I_WR && I_ADDR == adc_pls_pkg::OFS_RESULT_HI_TAG && !start_req && !done
        |=> $stable(opt_q) && $stable(pl_cnt_q) && $stable(rs_cnt_q) && $stable(st_q))
        else $error("write to offset 1 changed state");
    a_pl_push_count: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        wr_point && !pl_full && !pl_clr |=> pl_cnt_q == $past(pl_cnt_q) + 1'b1)
        else $error("point-list word write not counted");
    a_tag_stored: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        rs_push |=> rs_mem[$past(rs_wp_q)] == {$past(O_TAG_SELECT_BITS), $past(I_CONV_DATA)})
        else $error("result tag mismatch");
    a_ext_gated: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !opt_q[adc_pls_pkg::OPT_EXT_TRIG_EN] && !wr_start && !I_TIMER2_ZERO |-> !O_CONV_START)
        else $error("start without an enabled trigger");
    a_clear_queues: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        pl_clr && rs_clr |=> pl_cnt_q == '0 && rs_cnt_q == '0)
        else $error("queue clear failed");
    a_err_irq: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        rs_under && opt_q[adc_pls_pkg::OPT_ERR_IRQ_EN] |=> O_IRQ)
        else $error("empty read raised no interrupt");
    a_stat_clear_irq: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        rd_stat && !irq_set |=> !O_IRQ ##0 O_RVALID && O_RDATA[7] == $past(st_q == adc_pls_pkg::CONV_IDLE))
        else $error("status read did not clear interrupt");
    a_seq_wrap: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        done && !rd_point && !pl_clr && seq_q + 1'b1 >= pl_cnt_q |=> seq_q == '0)
        else $error("point list did not wrap");
endmodule : adc_pointlist_sequencer
`default_nettype wire

/* adc_host_model.sv */
// Host I/O master model for the block's register port
`default_nettype none
module adc_host_model (
    // Clock
    input  wire logic        i_clk,
    // Bus toward the block
    output logic      [2:0]  o_addr  = 3'h0,
    output logic             o_wr    = 1'b0,
    output logic             o_rd    = 1'b0,
    output logic             o_word  = 1'b0,
    output logic      [15:0] o_wdata = 16'h0000,
    // Read answer
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////
    // One write; data inverted after release so stale values never match
    task automatic write_io(input logic [2:0] a, input logic w, input logic [15:0] d);
        @(posedge i_clk);
        o_addr  <= a;
        o_word  <= w;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
    endtask
    // One read; answer taken in the cycle after the strobe edge
    task automatic read_io(input logic [2:0] a, input logic w,
                           output logic [15:0] d, output logic v);
        @(posedge i_clk);
        o_addr <= a;
        o_word <= w;
        o_rd   <= 1'b1;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        #1;
        d = i_rdata;
        v = i_rvalid;
    endtask
endmodule // adc_host_model
`default_nettype wire

/* adc_pointlist_sequencer_bench.sv */
// Self-checking bench for the point-list sequencer
`default_nettype none
module adc_pointlist_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [15:0] entry; logic [11:0] data;} row_s;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  addr, rng, gain;
    logic        wr, rd, word, rvalid, irq, start, pair, vv;
    logic        ext_pin = 1'b0, tmr = 1'b0, done = 1'b0;
    logic [15:0] wdata, rdata, rv;
    logic [3:0]  chan, tag;
    logic [11:0] cdata = 12'h000;
    int          bad_count = 0, checked = 0, starts = 0;
    // Every range code, both input modes, distinct tags
    row_s rows [8] = '{'{16'hA0F0, 12'h800}, '{16'h5179, 12'h7FF}, '{16'hC2E2, 12'h001},
                      '{16'h336B, 12'hFFF}, '{16'hF404, 12'h123}, '{16'h075D, 12'hABC},
                      '{16'h96A6, 12'h555}, '{16'h672F, 12'hAAA}};
    ////////////////////////////////////////////////////////////////////////
    // Small depths keep the fill and overflow cases short
    adc_pointlist_sequencer #(.PL_DEPTH(8), .RES_DEPTH(8)) dut (
        .I_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WR(wr), .I_RD(rd),
        .I_WORD(word), .I_WDATA(wdata), .O_RDATA(rdata), .O_RVALID(rvalid),
        .O_IRQ(irq), .I_EXT_PIN_LEVEL(ext_pin), .I_TIMER2_ZERO(tmr),
        .O_CONV_START(start), .O_CHANNEL_NUMBER(chan), .O_PAIR_INPUT_MODE(pair),
        .O_RANGE_CODE(rng), .O_TAG_SELECT_BITS(tag), .O_GAIN_BITS(gain),
        .I_CONV_DONE(done), .I_CONV_DATA(cdata));
    adc_host_model host (
        .i_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_word(word),
        .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));
    ////////////////////////////////////////////////////////////////////////
    // Clock and start counter
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (start === 1'b1) starts++;
    end
    // Single compare for all results, widened to a word
    task automatic check_val(input string what, input logic [15:0] exp,
                             input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Read with answer strobe and masked value check
    task automatic rd_chk(input logic [2:0] a, input logic w, input logic [15:0] m,
                          input logic [15:0] exp, input string what);
        host.read_io(a, w, rv, vv);
        check_val("read valid", 16'h0001, {15'h0000, vv});
        check_val(what, exp, rv & m);
    endtask
    task automatic irq_is(input logic exp);
        repeat (2) @(posedge clk);
        #1;
        check_val("irq", {15'h0000, exp}, {15'h0000, irq});
    endtask
    // Software start, field check, optional busy check, then converter answer
    task automatic convert(input logic [11:0] d, input logic [15:0] e, input logic look);
        int s0;
        s0 = starts;
        host.write_io(3'h0, 1'b0, {4'h0, d});
        #1;
        check_val("start count", 16'(s0 + 1), 16'(starts));
        check_val("entry fields", e & 16'hF7FF,
                  {tag, 1'b0, gain, chan, pair, rng});
        if (look) rd_chk(3'h4, 1'b0, 16'h0080, 16'h0000, "busy bit");
        @(posedge clk);
        done  <= 1'b1;
        cdata <= d;
        @(posedge clk);
        done  <= 1'b0;
        cdata <= ~d;
    endtask
    // Pin or timer pulse for one cycle; more is the expected number of new starts
    task automatic trig(input logic e, input logic t, input int more);
        int s0;
        s0 = starts;
        @(posedge clk);
        ext_pin <= e;
        tmr     <= t;
        @(posedge clk);
        ext_pin <= 1'b0;
        tmr     <= 1'b0;
        @(posedge clk);
        done    <= 1'b1;
        @(posedge clk);
        done    <= 1'b0;
        #1;
        check_val("trigger starts", 16'(s0 + more), 16'(starts));
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence; option writes keep reserved bits 5 and 4 at zero
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_chk(3'h4, 1'b0, 16'h00FF, 16'h00EC, "reset status");
        check_val("reset irq", 16'h0000, {15'h0000, irq});
        foreach (rows[i]) host.write_io(3'h2, 1'b1, rows[i].entry);
        host.write_io(3'h2, 1'b1, 16'h1111);
        rd_chk(3'h4, 1'b0, 16'h0070, 16'h0010, "list full flags");
        rd_chk(3'h2, 1'b1, 16'hF7FF, rows[0].entry, "list readback");
        rd_chk(3'h3, 1'b0, 16'h00FF, {8'h00, rows[0].entry[15:8]}, "list high byte");
        foreach (rows[i]) begin
            convert(rows[i].data, rows[i].entry, 1'b1);
            rd_chk(3'h0, 1'b1, 16'hFFFF, {rows[i].entry[15:12], rows[i].data},
                   "result word");
        end
        convert(12'h321, rows[0].entry, 1'b0);
        rd_chk(3'h0, 1'b0, 16'h00FF, 16'h0021, "low byte");
        rd_chk(3'h1, 1'b0, 16'h00FF, {8'h00, rows[0].entry[15:12], 4'h3}, "high byte");
        host.write_io(3'h1, 1'b0, 16'h00FF);
        rd_chk(3'h4, 1'b0, 16'h00FF, 16'h009C, "status after offset 1");
        check_val("offset 1 starts", 16'(9), 16'(starts));
        // Empty read error, then status read clears it
        host.write_io(3'h4, 1'b0, 16'h0002);
        rd_chk(3'h0, 1'b1, 16'hFFFF, 16'h0000, "empty read");
        irq_is(1'b1);
        rd_chk(3'h4, 1'b0, 16'h00FF, 16'h009C, "status clear");
        irq_is(1'b0);
        // Half-full interrupt, then overflow loses the ninth result
        host.write_io(3'h4, 1'b0, 16'h0004);
        for (int j = 0; j < 9; j++) begin
            convert(12'h100 + 12'(j), rows[(1 + j) % 8].entry, 1'b0);
            if (j == 2) irq_is(1'b0);
            if (j == 3) begin
                irq_is(1'b1);
                rd_chk(3'h4, 1'b0, 16'h00FF, 16'h009A, "status half");
                irq_is(1'b0);
                host.write_io(3'h4, 1'b0, 16'h0002);
            end
        end
        irq_is(1'b1);
        for (int j = 0; j < 8; j++) begin
            rd_chk(3'h0, 1'b1, 16'hFFFF, {rows[(1 + j) % 8].entry[15:12], 12'h100 + 12'(j)},
                   "fifo order");
        end
        // Queue clears, then trigger sources
        convert(12'h0AA, rows[2].entry, 1'b0);
        host.write_io(3'h4, 1'b0, 16'h0048);
        rd_chk(3'h4, 1'b0, 16'h00FF, 16'h00EC, "cleared status");
        trig(1'b1, 1'b0, 0);
        trig(1'b0, 1'b1, 0);
        host.write_io(3'h4, 1'b0, 16'h0080);
        trig(1'b1, 1'b0, 1);
        host.write_io(3'h4, 1'b0, 16'h0001);
        trig(1'b0, 1'b1, 1);
        trig(1'b1, 1'b0, 0);
        // Reset in mid-run must empty the queues and drop the timer enable
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(3'h4, 1'b0, 16'h00FF, 16'h00EC, "second reset status");
        trig(1'b0, 1'b1, 0);
        report_and_stop();
    end
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #100us;
        bad_count++;
        $display("BAD watchdog expected finish seen timeout");
        report_and_stop();
    end
endmodule // adc_pointlist_sequencer_bench
`default_nettype wire
